// *** rtl/i2c_interrupt_status_logic.sv ***
// interrupt status flags, fifo level tracking and bus condition detection
`timescale 1ns/1ns
`include "i2c_intr_regs.svh"

module i2c_interrupt_status_logic
(
	input  wire logic                          clk_i,
	input  wire logic                          arst_n_i,
	input  wire logic                          ce_i,
	// two-wire bus pins
	input  wire logic                          scl_i,
	output logic                               scl_o,
	output logic                               scl_oe_o,
	input  wire logic                          sda_i,
	// configuration from the surrounding register file
	input  wire logic                          enable_i,
	input  wire logic [15:0]                   mask_i,
	input  wire i2c_intr_pkg::threshold_t      transmit_threshold_register_i,
	input  wire i2c_intr_pkg::threshold_t      receive_threshold_i,
	// clear-register read strobes
	input  wire logic                          combined_clear_register_rd_i,
	input  wire logic                          activity_clear_register_rd_i,
	input  wire logic                          abort_clear_register_rd_i,
	input  wire logic                          read_request_clear_register_rd_i,
	// events from the master and slave state machines
	input  wire logic                          ctrl_active_i,
	input  wire logic                          slave_tx_nack_i,
	input  wire logic                          tx_abort_i,
	input  wire i2c_intr_pkg::abort_reason_t   abort_cause_i,
	input  wire logic                          slave_read_req_i,
	input  wire logic                          rx_byte_i,
	input  wire logic                          tx_pop_i,
	// data and command register accesses
	input  wire logic                          data_cmd_wr_i,
	input  wire logic                          data_cmd_rd_i,
	// register read port
	input  wire i2c_intr_pkg::addr_t           reg_addr_i,
	input  wire logic                          reg_rd_i,
	input  wire logic                          reg_wr_i,
	input  wire i2c_intr_pkg::status_t         reg_wdata_i,
	output i2c_intr_pkg::status_t              reg_rdata_o,
	// fifo control
	output logic                               tx_push_o,
	output logic                               tx_flush_o,
	output logic                               rx_push_o,
	output logic                               rx_flush_o,
	output i2c_intr_pkg::level_t               tx_level_o,
	output i2c_intr_pkg::level_t               rx_level_o,
	output i2c_intr_pkg::abort_reason_t        abort_reason_register_o,
	output logic                               internal_enable_signal_o,
	output i2c_intr_pkg::status_t              masked_status_o
);

	// pin synchronisers and filtered levels, bit 1 scl, bit 0 sda
	logic [1:0]                  pin_s1_q;
	logic [1:0]                  pin_s2_q;
	logic [1:0]                  pin_s3_q;
	logic [1:0]                  pin_f_q;
	logic [1:0]                  pin_f_d;
	logic [1:0]                  pin_agree;

	// flags
	logic                        start_seen_flag_q;
	logic                        stop_seen_flag_q;
	logic                        activity_q;
	logic                        tx_done_q;
	logic                        transmit_abort_flag_q;
	logic                        read_request_q;
	logic                        tx_empty_q;
	logic                        tx_over_q;
	logic                        rx_threshold_q;
	logic                        rx_over_q;
	logic                        rx_under_q;
	logic                        internal_enable_signal_q;

	// fifo levels and recorded abort cause
	i2c_intr_pkg::level_t        tx_level_q;
	i2c_intr_pkg::level_t        rx_level_q;
	i2c_intr_pkg::abort_reason_t abort_reason_q;
	i2c_intr_pkg::status_t       rdata_q;

	// decoded terms
	logic                        start_det;
	logic                        stop_det;
	logic                        tx_full;
	logic                        tx_empty_fifo;
	logic                        rx_full;
	logic                        rx_empty;
	logic                        tx_accept;
	logic                        tx_drain;
	logic                        rx_accept;
	logic                        rx_drain;
	logic                        stat_hit;
	logic                        tx_empty_d;
	logic                        rx_threshold_d;
	i2c_intr_pkg::status_t       raw_status;
	i2c_intr_pkg::status_t       masked_status;

	// three-stage pin sampling; s1 feeds only s2
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pin_s1_q <= 2'h3;
			pin_s2_q <= 2'h3;
			pin_s3_q <= 2'h3;
			pin_f_q  <= 2'h3;
		end
		else if (ce_i)
		begin
			pin_s1_q <= {scl_i, sda_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q  <= pin_f_d;
		end
	end

	// a pin change counts only once stages two and three agree
	assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
	assign pin_f_d   = (pin_agree & pin_s2_q) | (~pin_agree & pin_f_q);

	// sda edges while scl stays high mark start and stop
	assign start_det = pin_f_q[1] & pin_f_d[1] & pin_f_q[0] & ~pin_f_d[0];
	assign stop_det  = pin_f_q[1] & pin_f_d[1] & ~pin_f_q[0] & pin_f_d[0];

	// fifo state decode
	assign tx_full       = (tx_level_q == `FIFO_DEPTH);
	assign tx_empty_fifo = (tx_level_q == `LEVEL_ZERO);
	assign rx_full       = (rx_level_q == `FIFO_DEPTH);
	assign rx_empty      = (rx_level_q == `LEVEL_ZERO);

	// aborted or disabled tx fifo refuses every new byte
	assign tx_accept = data_cmd_wr_i & enable_i & ~transmit_abort_flag_q & ~tx_full;
	assign tx_drain  = tx_pop_i & ~tx_empty_fifo;
	// a byte arriving at full is still acked on the bus but dropped here
	assign rx_accept = rx_byte_i & enable_i & ~rx_full;
	assign rx_drain  = data_cmd_rd_i & ~rx_empty;

	// tx level tracking; flushed while disabled or aborted
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			tx_level_q <= `LEVEL_ZERO;
		else if (ce_i)
		begin
			if (!enable_i || transmit_abort_flag_q)
				tx_level_q <= `LEVEL_ZERO;
			else if (tx_accept && !tx_drain)
				tx_level_q <= tx_level_q + 6'h01;
			else if (tx_drain && !tx_accept)
				tx_level_q <= tx_level_q - 6'h01;
		end
	end

	// rx level tracking; flushed while disabled
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rx_level_q <= `LEVEL_ZERO;
		else if (ce_i)
		begin
			if (!enable_i)
				rx_level_q <= `LEVEL_ZERO;
			else if (rx_accept && !rx_drain)
				rx_level_q <= rx_level_q + 6'h01;
			else if (rx_drain && !rx_accept)
				rx_level_q <= rx_level_q - 6'h01;
		end
	end

	// internal enable lingers until the state machines go idle
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			internal_enable_signal_q <= 1'b0;
		else if (ce_i)
			internal_enable_signal_q <= enable_i | (internal_enable_signal_q & ctrl_active_i);
	end

	// bus condition flags; set wins over the combined clear
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			start_seen_flag_q <= 1'b0;
			stop_seen_flag_q  <= 1'b0;
		end
		else if (ce_i)
		begin
			start_seen_flag_q <= start_det | (start_seen_flag_q & ~combined_clear_register_rd_i);
			stop_seen_flag_q  <= stop_det | (stop_seen_flag_q & ~combined_clear_register_rd_i);
		end
	end

	// sticky activity; only disable, the two clear reads or reset drop it
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			activity_q <= 1'b0;
		else if (ce_i)
			activity_q <= ctrl_active_i | (activity_q & enable_i
				& ~activity_clear_register_rd_i & ~combined_clear_register_rd_i);
	end

	// slave transmit completion on remote nack
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			tx_done_q <= 1'b0;
		else if (ce_i)
			tx_done_q <= slave_tx_nack_i | (tx_done_q & ~combined_clear_register_rd_i);
	end

	// transmit abort with its recorded cause
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			transmit_abort_flag_q <= 1'b0;
			abort_reason_q        <= `ABORT_REASON_RESET;
		end
		else if (ce_i)
		begin
			transmit_abort_flag_q <= tx_abort_i | (transmit_abort_flag_q
				& ~abort_clear_register_rd_i & ~combined_clear_register_rd_i);
			if (tx_abort_i)
				abort_reason_q <= abort_cause_i;
		end
	end

	// read request stalls the bus until the processor clears it
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			read_request_q <= 1'b0;
		else if (ce_i)
			read_request_q <= slave_read_req_i | (read_request_q
				& ~read_request_clear_register_rd_i & ~combined_clear_register_rd_i);
	end

	// threshold flags follow fifo levels, no latching; tx empty tracks ctrl_active_i while disabled
	assign tx_empty_d = enable_i ? ({2'b00, tx_level_q} <= transmit_threshold_register_i)
		: ctrl_active_i;
	assign rx_threshold_d = enable_i & ({2'b00, rx_level_q} >= receive_threshold_i);

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tx_empty_q     <= 1'b0;
			rx_threshold_q <= 1'b0;
		end
		else if (ce_i)
		begin
			tx_empty_q     <= tx_empty_d;
			rx_threshold_q <= rx_threshold_d;
		end
	end

	// error flags keep level through disable until internal enable falls
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tx_over_q  <= 1'b0;
			rx_over_q  <= 1'b0;
			rx_under_q <= 1'b0;
		end
		else if (ce_i)
		begin
			tx_over_q  <= (data_cmd_wr_i & tx_full) | (tx_over_q & internal_enable_signal_q
				& ~combined_clear_register_rd_i);
			rx_over_q  <= (rx_byte_i & rx_full) | (rx_over_q & internal_enable_signal_q
				& ~combined_clear_register_rd_i);
			rx_under_q <= (data_cmd_rd_i & rx_empty) | (rx_under_q & internal_enable_signal_q
				& ~combined_clear_register_rd_i);
		end
	end

	// raw flag vector; bits 15 to 11 are not produced here
	always_comb
	begin
		raw_status                    = `STATUS_MASKED_RESET;
		raw_status[`BIT_START_SEEN]   = start_seen_flag_q;
		raw_status[`BIT_STOP_SEEN]    = stop_seen_flag_q;
		raw_status[`BIT_ACTIVITY]     = activity_q;
		raw_status[`BIT_TX_DONE]      = tx_done_q;
		raw_status[`BIT_TX_ABORT]     = transmit_abort_flag_q;
		raw_status[`BIT_READ_REQUEST] = read_request_q;
		raw_status[`BIT_TX_EMPTY]     = tx_empty_q;
		raw_status[`BIT_TX_OVER]      = tx_over_q;
		raw_status[`BIT_RX_THRESHOLD] = rx_threshold_q;
		raw_status[`BIT_RX_OVER]      = rx_over_q;
		raw_status[`BIT_RX_UNDER]     = rx_under_q;
	end

	// mask gating, reserved field forced low
	assign masked_status = raw_status & mask_i & ~`STATUS_RESERVED_MASK;

	// read decode; a write to this address has no target
	assign stat_hit = (reg_addr_i == `STATUS_MASKED_OFFSET);

	// read data registered; unmapped reads and all writes return zero
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_q <= `STATUS_MASKED_RESET;
		else if (ce_i)
			rdata_q <= (reg_rd_i && stat_hit && !reg_wr_i) ? masked_status : `STATUS_MASKED_RESET;
	end

	// reg_wdata_i is accepted on the port but never stored
	assign reg_rdata_o = rdata_q;

	// scl pulled low while the read request waits; relies on the
	// processor loading data before clearing the request
	assign scl_o    = 1'b0;
	assign scl_oe_o = read_request_q;

	// fifo control strobes
	assign tx_push_o  = tx_accept;
	assign tx_flush_o = ~enable_i | transmit_abort_flag_q;
	assign rx_push_o  = rx_accept;
	assign rx_flush_o = ~enable_i;

	// observable state
	assign tx_level_o               = tx_level_q;
	assign rx_level_o               = rx_level_q;
	assign abort_reason_register_o  = abort_reason_q;
	assign internal_enable_signal_o = internal_enable_signal_q;

	// masked status mirrored from flags each cycle
	always_comb
	begin
		masked_status_o = masked_status;
	end

endmodule

// *** common/i2c_intr_regs.svh ***
// offsets, field positions, reset values and depths of the interrupt status logic
`ifndef I2C_INTR_REGS_SVH
`define I2C_INTR_REGS_SVH

`define STATUS_MASKED_OFFSET 32'h5000_132c
`define STATUS_MASKED_RESET  16'h0000
`define STATUS_RESERVED_MASK 16'hf000

`define BIT_START_SEEN   10
`define BIT_STOP_SEEN    9
`define BIT_ACTIVITY     8
`define BIT_TX_DONE      7
`define BIT_TX_ABORT     6
`define BIT_READ_REQUEST 5
`define BIT_TX_EMPTY     4
`define BIT_TX_OVER      3
`define BIT_RX_THRESHOLD 2
`define BIT_RX_OVER      1
`define BIT_RX_UNDER     0

`define FIFO_DEPTH       6'h20
`define LEVEL_ZERO       6'h00
`define ABORT_REASON_RESET 16'h0000

`endif

// *** common/i2c_intr_pkg.sv ***
// types shared by the interrupt status logic
package i2c_intr_pkg;
	typedef logic [15:0] status_t;
	typedef logic [5:0]  level_t;
	typedef logic [7:0]  threshold_t;
	typedef logic [15:0] abort_reason_t;
	typedef logic [31:0] addr_t;
endpackage

// *** bench/i2c_intr_sva.sv ***
// port assertions for the interrupt status logic
`timescale 1ns/1ns
`include "i2c_intr_regs.svh"
module i2c_intr_sva
(
	input wire logic                        clk_i,
	input wire logic                        arst_n_i,
	input wire logic                        ce_i,
	input wire logic                        scl_o,
	input wire logic                        scl_oe_o,
	input wire logic                        enable_i,
	input wire logic [15:0]                 mask_i,
	input wire logic                        read_request_clear_register_rd_i,
	input wire logic                        tx_abort_i,
	input wire i2c_intr_pkg::abort_reason_t abort_cause_i,
	input wire logic                        slave_read_req_i,
	input wire logic                        rx_byte_i,
	input wire logic                        data_cmd_wr_i,
	input wire logic                        data_cmd_rd_i,
	input wire i2c_intr_pkg::addr_t         reg_addr_i,
	input wire logic                        reg_rd_i,
	input wire logic                        reg_wr_i,
	input wire i2c_intr_pkg::status_t       reg_rdata_o,
	input wire logic                        tx_push_o,
	input wire logic                        tx_flush_o,
	input wire logic                        rx_push_o,
	input wire logic                        rx_flush_o,
	input wire i2c_intr_pkg::level_t        tx_level_o,
	input wire i2c_intr_pkg::level_t        rx_level_o,
	input wire i2c_intr_pkg::abort_reason_t abort_reason_register_o,
	input wire i2c_intr_pkg::status_t       masked_status_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// a full fifo meeting one more unit is the only overflow cause
	sequence s_wr_full;
		ce_i && enable_i && data_cmd_wr_i && tx_level_o == `FIFO_DEPTH;
	endsequence
	sequence s_rx_full;
		ce_i && enable_i && rx_byte_i && rx_level_o == `FIFO_DEPTH;
	endsequence
	AST_TX_OVER: assert property (s_wr_full |-> !tx_push_o ##1 (masked_status_o[3] || !mask_i[3]))
		else $error("tx overflow flag missing");
	AST_RX_OVER: assert property (s_rx_full |-> !rx_push_o ##1 (masked_status_o[1] || !mask_i[1]))
		else $error("rx overflow flag missing");
	AST_ABORT: assert property (ce_i && tx_abort_i |=>
		abort_reason_register_o == $past(abort_cause_i) && (masked_status_o[6] || !mask_i[6]))
		else $error("abort flag or reason wrong");
	AST_FLUSH: assert property (masked_status_o[6] || !enable_i |-> tx_flush_o && !tx_push_o)
		else $error("tx fifo not held flushed");
	AST_RDREQ: assert property (ce_i && slave_read_req_i |=> scl_oe_o && !scl_o)
		else $error("clock line not held low");
	AST_RDCLR: assert property (ce_i && read_request_clear_register_rd_i && !slave_read_req_i |=> !scl_oe_o)
		else $error("read request not released");
	AST_RXDIS: assert property (ce_i && !enable_i |-> rx_flush_o && !rx_push_o ##1 !masked_status_o[2])
		else $error("rx not flushed on disable");
	AST_UNDER: assert property (ce_i && enable_i && data_cmd_rd_i && rx_level_o == `LEVEL_ZERO |=>
		masked_status_o[0] || !mask_i[0])
		else $error("rx underflow flag missing");
	AST_MASK: assert property ((masked_status_o & ~mask_i) == 16'h0000)
		else $error("unmasked flag visible");
	AST_RSVD: assert property (masked_status_o[15:12] == 4'h0)
		else $error("reserved bits set");
	AST_READ: assert property (ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == `STATUS_MASKED_OFFSET |=>
		reg_rdata_o == $past(masked_status_o))
		else $error("status read data wrong");
	AST_WRITE: assert property (ce_i && reg_wr_i |=> reg_rdata_o == 16'h0000)
		else $error("write not ignored");
endmodule
bind i2c_interrupt_status_logic i2c_intr_sva i_i2c_intr_sva (.clk_i, .arst_n_i, .ce_i, .scl_o, .scl_oe_o,
	.enable_i, .mask_i, .read_request_clear_register_rd_i, .tx_abort_i, .abort_cause_i, .slave_read_req_i,
	.rx_byte_i, .data_cmd_wr_i, .data_cmd_rd_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_rdata_o, .tx_push_o,
	.tx_flush_o, .rx_push_o, .rx_flush_o, .tx_level_o, .rx_level_o, .abort_reason_register_o, .masked_status_o);

// *** bench/bus_peer.sv ***
// remote bus master model: one short frame per request
`timescale 1ns/1ns
module bus_peer
(
	input  wire logic go_i,
	output logic      scl_o,
	output logic      sda_o
);
	// pulled-up bus idles high, clock still outside frames
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// start, four 800 ns clocks, then stop
	always @(posedge go_i)
	begin
		sda_o = 1'b0;
		#400;
		repeat (4)
		begin
			scl_o = 1'b0;
			#200;
			sda_o = ~sda_o;
			#200;
			scl_o = 1'b1;
			#400;
		end
		scl_o = 1'b0;
		sda_o = 1'b0;
		#400;
		scl_o = 1'b1;
		#400;
		sda_o = 1'b1;
	end
endmodule

// *** bench/i2c_interrupt_status_logic_test.sv ***
// self-checking bench for the interrupt status logic
`timescale 1ns/1ns
`include "i2c_intr_regs.svh"
module i2c_interrupt_status_logic_test;
	logic                  clk_i = 1'b0;
	logic                  arst_n_i = 1'b0;
	logic                  enable_i = 1'b0;
	logic                  ctrl_active_i = 1'b0;
	logic                  reg_rd_i = 1'b0;
	logic                  reg_wr_i = 1'b0;
	logic                  go = 1'b0;
	logic [10:0]           ev = 11'h000;
	i2c_intr_pkg::status_t mask_i = 16'hffff;
	i2c_intr_pkg::addr_t   reg_addr_i = `STATUS_MASKED_OFFSET;
	i2c_intr_pkg::status_t rdata;
	i2c_intr_pkg::level_t  txl;
	i2c_intr_pkg::level_t  rxl;
	i2c_intr_pkg::abort_reason_t why;
	logic                  oe;
	logic                  pscl;
	logic                  psda;
	logic                  ien;
	i2c_intr_pkg::status_t ms;
	int                    err_count = 0;
	int                    checks = 0;
	int                    i;
	// free-running system clock
	always #50 clk_i = ~clk_i;
	// device pulls the clock wire low over the peer's level
	i2c_interrupt_status_logic i_i2c_interrupt_status_logic
	(
		.clk_i, .arst_n_i, .ce_i(1'b1), .scl_i(pscl & ~oe), .scl_o(), .scl_oe_o(oe), .sda_i(psda), .enable_i,
		.mask_i, .transmit_threshold_register_i(8'h00), .receive_threshold_i(8'h02),
		.combined_clear_register_rd_i(ev[0]), .activity_clear_register_rd_i(ev[1]),
		.abort_clear_register_rd_i(ev[2]), .read_request_clear_register_rd_i(ev[3]), .ctrl_active_i,
		.slave_tx_nack_i(ev[4]), .tx_abort_i(ev[5]), .abort_cause_i(16'h00a5), .slave_read_req_i(ev[6]),
		.rx_byte_i(ev[7]), .tx_pop_i(ev[8]), .data_cmd_wr_i(ev[9]), .data_cmd_rd_i(ev[10]), .reg_addr_i,
		.reg_rd_i, .reg_wr_i, .reg_wdata_i(16'hffff), .reg_rdata_o(rdata), .tx_push_o(), .tx_flush_o(),
		.rx_push_o(), .rx_flush_o(), .tx_level_o(txl), .rx_level_o(rxl), .abort_reason_register_o(why),
		.internal_enable_signal_o(ien), .masked_status_o(ms)
	);
	bus_peer i_bus_peer (.go_i(go), .scl_o(pscl), .sda_o(psda));
	task automatic chk(input i2c_intr_pkg::status_t seen, input i2c_intr_pkg::status_t exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle strobe on event line k, n times with a gap
	task automatic pulse(input int k, input int n);
		repeat (n)
		begin
			@(negedge clk_i);
			ev[k] = 1'b1;
			@(negedge clk_i);
			ev[k] = 1'b0;
		end
	endtask
	// read answer is sampled in the cycle after the taking edge
	task automatic stat(input i2c_intr_pkg::status_t exp, input i2c_intr_pkg::addr_t a = `STATUS_MASKED_OFFSET);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		chk(rdata, exp);
		reg_rd_i = 1'b0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(negedge clk_i);
		arst_n_i = 1'b1;
		stat(16'h0000);
		enable_i = 1'b1;
		// a read cycle that also carries a write must answer zero
		@(negedge clk_i);
		reg_wr_i = 1'b1;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		chk(rdata, 16'h0000);
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		stat(16'h0010);
		pulse(10, 1);
		stat(16'h0011);
		pulse(9, 1);
		stat(16'h0001);
		@(negedge clk_i);
		ctrl_active_i = 1'b1;
		repeat (2) @(negedge clk_i);
		ctrl_active_i = 1'b0;
		stat(16'h0101);
		pulse(1, 1);
		stat(16'h0001);
		pulse(4, 1);
		stat(16'h0081);
		pulse(5, 1);
		// flush lands one edge after the flag, the empty flag one edge later
		@(negedge clk_i);
		stat(16'h00d1);
		chk(why, 16'h00a5);
		pulse(9, 1);
		chk({10'h000, txl}, 16'h0000);
		pulse(2, 1);
		stat(16'h0091);
		pulse(9, 1);
		stat(16'h0081);
		pulse(6, 1);
		stat(16'h00a1);
		chk({15'h0000, oe}, 16'h0001);
		stat(16'h0000, 32'h5000_1330);
		pulse(9, 1);
		pulse(3, 1);
		stat(16'h0081);
		chk({15'h0000, oe}, 16'h0000);
		pulse(0, 1);
		stat(16'h0000);
		// wait for start and stop to pass the pin filter, bounded
		go = 1'b1;
		for (i = 0; i < 400 && ms !== 16'h0600; i++)
			@(negedge clk_i);
		go = 1'b0;
		if (i == 400)
			err_count++;
		stat(16'h0600);
		pulse(0, 1);
		pulse(9, 31);
		stat(16'h0008);
		chk({10'h000, txl}, 16'h0020);
		pulse(8, 1);
		chk({10'h000, txl}, 16'h001f);
		pulse(7, 2);
		stat(16'h000c);
		pulse(7, 31);
		stat(16'h000e);
		mask_i = 16'hfeff;
		ctrl_active_i = 1'b1;
		enable_i = 1'b0;
		repeat (3) @(negedge clk_i);
		stat(16'h001a);
		chk({15'h0000, ien}, 16'h0001);
		ctrl_active_i = 1'b0;
		repeat (4) @(negedge clk_i);
		mask_i = 16'hffff;
		stat(16'h0000);
		chk({10'h000, rxl}, 16'h0000);
		chk({15'h0000, ien}, 16'h0000);
		summarize();
	end
endmodule
